// ---- hw/nvsram_i2c_slave_port.sv ----
// Two-wire serial slave port with 8K x 8 memory behind it
// ****************************************
// What this block does
// - SDA fall with SCL high starts transaction
// - SDA rise with SCL high stops transaction
// - Data changes only while SCL is low
// - Bus busy from START until STOP
// - Repeated START restarts at slave select
// - Seven-bit addressing only
// - Select byte is address plus direction
// - Ack own address, else ignore until condition
// - Eight bits, MSB first, then acknowledge
// - Receiver pulls low on ninth pulse
// - Missing acknowledge aborts the operation
// - Acknowledge every unprotected written byte
// - Address steps after each unprotected data byte, eighth fall
// - Address wraps past last location
// - Read returns data at current address
// - Master nack ends read, line released
// - Protected write byte is not acknowledged
// - Works with SCL up to 3.4 MHz
// - Memory answers to 1010b plus straps
// - Two address bytes, top three ignored
// - Master code unacked, high speed until STOP
// ****************************************
module nvsram_i2c_slave_port (
  // Core clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Link sampling clock
  input wire logic link_clk_i,
  // Two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Straps
  input wire logic [nvsram_i2c_pkg::STRAP_W-1:0] slave_select_straps_i,
  input wire logic write_protect_i,
  // Status in core domain
  output logic bus_busy_o,
  output logic hs_mode_o,
  output logic write_strobe_o
);

  // ****************************************
  // Crossings into the link domain
  // ****************************************
  logic link_rst;
  nvsram_i2c_pkg::link_in_t link_in;
  nvsram_i2c_pkg::link_in_t pins_raw;

  assign pins_raw = '{write_protect: write_protect_i, straps: slave_select_straps_i,
                      sda: sda_i, scl: scl_i};

  bit_sync #(.WIDTH(1)) rst_to_link (
    .clk_i(link_clk_i),
    .d_i(rst_i),
    .q_o(link_rst)
  );

  bit_sync #(.WIDTH(nvsram_i2c_pkg::LINK_IN_W)) pins_to_link (
    .clk_i(link_clk_i),
    .d_i(pins_raw),
    .q_o(link_in)
  );

  // ****************************************
  // Bus condition decode
  // ****************************************
  logic scl_q;
  logic sda_q;

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= link_in.scl;
      sda_q <= link_in.sda;
    end
  end

  wire scl_rise = link_in.scl & ~scl_q;
  wire scl_fall = ~link_in.scl & scl_q;
  wire start_cond = link_in.scl & scl_q & sda_q & ~link_in.sda;
  wire stop_cond = link_in.scl & scl_q & ~sda_q & link_in.sda;

  // ****************************************
  // Engine state
  // ****************************************
  nvsram_i2c_pkg::link_state_t state;
  nvsram_i2c_pkg::byte_phase_t phase;
  logic [3:0] bit_cnt;
  logic [nvsram_i2c_pkg::BYTE_W-1:0] rx_shift;
  logic [nvsram_i2c_pkg::BYTE_W-1:0] tx_shift;
  logic [nvsram_i2c_pkg::ADDR_W-1:0] mem_addr;
  logic [nvsram_i2c_pkg::BYTE_W-1:0] rd_data;
  logic read_dir;
  logic master_ack;
  logic busy;
  logic hs_mode;
  logic sda_oe;
  logic write_toggle;
  logic [nvsram_i2c_pkg::BYTE_W-1:0] mem [nvsram_i2c_pkg::MEM_DEPTH];

  function automatic logic [nvsram_i2c_pkg::ADDR_W-1:0] bump_addr(
    input logic [nvsram_i2c_pkg::ADDR_W-1:0] a
  );
    bump_addr = (a == nvsram_i2c_pkg::ADDR_LAST) ? nvsram_i2c_pkg::ADDR_FIRST
                                                 : a + nvsram_i2c_pkg::ADDR_STEP;
  endfunction

  wire byte_done_fall = scl_fall & (bit_cnt == nvsram_i2c_pkg::BIT_CNT_FULL);
  wire rx_byte_end = (state == nvsram_i2c_pkg::ST_RX) & byte_done_fall;
  wire select_hit = (rx_shift[7:4] == nvsram_i2c_pkg::MEM_DEV_CODE) &
                    (rx_shift[3:1] == link_in.straps);
  wire master_code = rx_shift[7:3] == nvsram_i2c_pkg::MASTER_CODE_TOP;
  // Protected data byte gets no acknowledge
  wire rx_ack = (phase == nvsram_i2c_pkg::PH_SELECT) ? select_hit :
                (phase == nvsram_i2c_pkg::PH_DATA) ? ~link_in.write_protect : 1'b1;
  wire mem_write = rx_byte_end & (phase == nvsram_i2c_pkg::PH_DATA) & ~link_in.write_protect;
  wire [nvsram_i2c_pkg::ADDR_W-1:0] addr_next = bump_addr(mem_addr);
  wire [1:0] phase_after = (phase == nvsram_i2c_pkg::PH_SELECT) ? nvsram_i2c_pkg::PH_ADDR_HI :
                           (phase == nvsram_i2c_pkg::PH_ADDR_HI) ? nvsram_i2c_pkg::PH_ADDR_LO :
                           nvsram_i2c_pkg::PH_DATA;

  // ****************************************
  // Protocol engine
  // ****************************************
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      state <= nvsram_i2c_pkg::ST_IDLE;
      phase <= nvsram_i2c_pkg::PH_SELECT;
      bit_cnt <= nvsram_i2c_pkg::BIT_CNT_FIRST;
      rx_shift <= nvsram_i2c_pkg::BYTE_ZERO;
      tx_shift <= nvsram_i2c_pkg::BYTE_ZERO;
      mem_addr <= nvsram_i2c_pkg::ADDR_FIRST;
      read_dir <= 1'b0;
      master_ack <= 1'b0;
      busy <= 1'b0;
      hs_mode <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state <= nvsram_i2c_pkg::ST_RX;
      phase <= nvsram_i2c_pkg::PH_SELECT;
      bit_cnt <= nvsram_i2c_pkg::BIT_CNT_FIRST;
      busy <= 1'b1;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= nvsram_i2c_pkg::ST_IDLE;
      busy <= 1'b0;
      hs_mode <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        nvsram_i2c_pkg::ST_RX: begin
          // Shift in MSB first on rising edge
          if (scl_rise && bit_cnt != nvsram_i2c_pkg::BIT_CNT_FULL) begin
            rx_shift <= {rx_shift[6:0], link_in.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done_fall) begin
            bit_cnt <= nvsram_i2c_pkg::BIT_CNT_FIRST;
            sda_oe <= rx_ack;
            state <= rx_ack ? nvsram_i2c_pkg::ST_RX_ACK : nvsram_i2c_pkg::ST_IGNORE;
            phase <= nvsram_i2c_pkg::byte_phase_t'(phase_after);
            if (phase == nvsram_i2c_pkg::PH_SELECT) begin
              // Low bit of select byte is direction
              read_dir <= rx_shift[0];
              // Master code enters high speed mode
              if (master_code) begin
                hs_mode <= 1'b1;
              end
            end
            if (phase == nvsram_i2c_pkg::PH_ADDR_HI) begin
              mem_addr[nvsram_i2c_pkg::ADDR_W-1:8] <= rx_shift[nvsram_i2c_pkg::ADDR_HI_W-1:0];
            end
            if (phase == nvsram_i2c_pkg::PH_ADDR_LO) begin
              mem_addr[7:0] <= rx_shift;
            end
            // Address steps on the write byte fall
            if (mem_write) begin
              mem_addr <= addr_next;
            end
          end
        end
        nvsram_i2c_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            if (read_dir) begin
              state <= nvsram_i2c_pkg::ST_TX;
              tx_shift <= rd_data;
              sda_oe <= ~rd_data[7];
            end else begin
              state <= nvsram_i2c_pkg::ST_RX;
              sda_oe <= 1'b0;
            end
          end
        end
        nvsram_i2c_pkg::ST_TX: begin
          // Drive changes only on falling edge
          if (scl_fall) begin
            if (bit_cnt == nvsram_i2c_pkg::BIT_CNT_LAST_TX) begin
              state <= nvsram_i2c_pkg::ST_TX_ACK;
              bit_cnt <= nvsram_i2c_pkg::BIT_CNT_FIRST;
              sda_oe <= 1'b0;
              mem_addr <= addr_next;
            end else begin
              tx_shift <= {tx_shift[6:0], 1'b0};
              sda_oe <= ~tx_shift[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        nvsram_i2c_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            master_ack <= ~link_in.sda;
          end else if (scl_fall) begin
            if (master_ack) begin
              state <= nvsram_i2c_pkg::ST_TX;
              tx_shift <= rd_data;
              sda_oe <= ~rd_data[7];
            end else begin
              state <= nvsram_i2c_pkg::ST_IGNORE;
            end
          end
        end
        nvsram_i2c_pkg::ST_IDLE, nvsram_i2c_pkg::ST_IGNORE: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state <= nvsram_i2c_pkg::ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Memory array
  // ****************************************
  // Each accepted data byte lands in memory
  always_ff @(posedge link_clk_i) begin
    if (mem_write) begin
      mem[mem_addr] <= rx_shift;
    end
    rd_data <= mem[mem_addr];
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      write_toggle <= 1'b0;
    end else if (mem_write) begin
      write_toggle <= ~write_toggle;
    end
  end

  // Open drain, only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe;

  // ****************************************
  // Status into core domain
  // ****************************************
  nvsram_i2c_pkg::link_status_t link_status;
  nvsram_i2c_pkg::link_status_t core_status;
  logic toggle_prev;

  assign link_status = '{write_toggle: write_toggle, hs_mode: hs_mode, busy: busy};

  bit_sync #(.WIDTH(nvsram_i2c_pkg::CORE_IN_W)) status_to_core (
    .clk_i(clock_i),
    .d_i(link_status),
    .q_o(core_status)
  );

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bus_busy_o <= 1'b0;
      hs_mode_o <= 1'b0;
      write_strobe_o <= 1'b0;
      toggle_prev <= 1'b0;
    end else begin
      bus_busy_o <= core_status.busy;
      hs_mode_o <= core_status.hs_mode;
      write_strobe_o <= core_status.write_toggle ^ toggle_prev;
      toggle_prev <= core_status.write_toggle;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking link_cb @(posedge link_clk_i);
  endclocking
  default disable iff (link_rst);

  a_drive_on_low: assert property ($rose(sda_oe) |-> !link_in.scl)
    else $error("SDA drive began while SCL high");
  a_start_opens: assert property (start_cond |=> state == nvsram_i2c_pkg::ST_RX
    && bit_cnt == nvsram_i2c_pkg::BIT_CNT_FIRST && busy && !sda_oe)
    else $error("Start did not open a select byte");
  a_stop_closes: assert property (stop_cond |=> state == nvsram_i2c_pkg::ST_IDLE
    && !busy && !hs_mode && !sda_oe)
    else $error("Stop did not end the transaction");
  a_busy_held: assert property (busy && !stop_cond |=> busy)
    else $error("Bus busy dropped without stop");
  a_select_ack: assert property (rx_byte_end && phase == nvsram_i2c_pkg::PH_SELECT
    && select_hit |=> sda_oe && state == nvsram_i2c_pkg::ST_RX_ACK)
    else $error("Own select byte not acknowledged");
  a_select_miss: assert property (rx_byte_end && phase == nvsram_i2c_pkg::PH_SELECT
    && !select_hit |=> !sda_oe && state == nvsram_i2c_pkg::ST_IGNORE)
    else $error("Foreign select byte not ignored");
  a_master_code: assert property (rx_byte_end && phase == nvsram_i2c_pkg::PH_SELECT
    && master_code |=> hs_mode && !sda_oe)
    else $error("Master code mishandled");
  a_addr_step: assert property (mem_write && mem_addr != nvsram_i2c_pkg::ADDR_LAST
    |=> mem_addr == $past(mem_addr) + nvsram_i2c_pkg::ADDR_STEP)
    else $error("Address did not step after write");
  a_addr_wrap: assert property (mem_write && mem_addr == nvsram_i2c_pkg::ADDR_LAST
    |=> mem_addr == nvsram_i2c_pkg::ADDR_FIRST)
    else $error("Address did not wrap");
  a_protect_nack: assert property (rx_byte_end && phase == nvsram_i2c_pkg::PH_DATA
    && link_in.write_protect |-> !mem_write ##1 !sda_oe)
    else $error("Protected byte written or acknowledged");
  a_tx_release: assert property (state == nvsram_i2c_pkg::ST_TX && scl_fall
    && bit_cnt == nvsram_i2c_pkg::BIT_CNT_LAST_TX |=> !sda_oe
    && state == nvsram_i2c_pkg::ST_TX_ACK)
    else $error("Line not released for master acknowledge");
  a_nack_abort: assert property (state == nvsram_i2c_pkg::ST_TX_ACK && scl_fall
    && !master_ack |=> state == nvsram_i2c_pkg::ST_IGNORE ##1 !sda_oe)
    else $error("Read not aborted on nack");
  a_read_data: assert property (state == nvsram_i2c_pkg::ST_RX_ACK && scl_fall
    && read_dir |=> state == nvsram_i2c_pkg::ST_TX && tx_shift == $past(rd_data))
    else $error("Read did not load current data");
  a_byte_eight: assert property ($rose(state == nvsram_i2c_pkg::ST_RX_ACK)
    |-> $past(bit_cnt) == nvsram_i2c_pkg::BIT_CNT_FULL)
    else $error("Acknowledge before eight bits");
  a_drive_window: assert property (sda_oe |-> state == nvsram_i2c_pkg::ST_RX_ACK
    || state == nvsram_i2c_pkg::ST_TX)
    else $error("SDA pulled outside ack or transmit");

endmodule

// ---- hw/nvsram_i2c_pkg.sv ----
// Shared constants and types for the two-wire nonvolatile SRAM slave port
package nvsram_i2c_pkg;

  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int MEM_DEPTH = 8192;
  localparam int STRAP_W = 3;
  localparam int BYTE_W = 8;
  localparam int ADDR_HI_W = 5;
  localparam int LINK_IN_W = 6;
  localparam int CORE_IN_W = 3;

  // ****************************************
  // Field values and counts
  // ****************************************
  localparam logic [3:0] MEM_DEV_CODE = 4'ha;
  localparam logic [4:0] MASTER_CODE_TOP = 5'h01;
  localparam logic [3:0] BIT_CNT_FIRST = 4'h0;
  localparam logic [3:0] BIT_CNT_LAST_TX = 4'h7;
  localparam logic [3:0] BIT_CNT_FULL = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 13'h1fff;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 13'h0001;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

  // Highest serial clock the sampler is sized for, in kHz
  localparam int SCL_MAX_KHZ = 3400;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RX_ACK = 3'b011,
    ST_TX = 3'b010,
    ST_TX_ACK = 3'b110,
    ST_IGNORE = 3'b111
  } link_state_t;

  typedef enum logic [1:0] {
    PH_SELECT = 2'b00,
    PH_ADDR_HI = 2'b01,
    PH_ADDR_LO = 2'b11,
    PH_DATA = 2'b10
  } byte_phase_t;

  typedef struct packed {
    logic write_protect;
    logic [STRAP_W-1:0] straps;
    logic sda;
    logic scl;
  } link_in_t;

  typedef struct packed {
    logic write_toggle;
    logic hs_mode;
    logic busy;
  } link_status_t;

endpackage

// ---- hw/bit_sync.sv ----
// Two-flop synchroniser for levels entering a clock domain
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input wire logic clk_i,
  // Level in and synchronised level out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // First stage is read only by the second
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o <= meta;
  end

endmodule

// ---- verification/i2c_master_model.sv ----
// Behavioural two-wire bus master that drives the slave port
module i2c_master_model (
  // Core clock paces the bus
  input wire logic clock_i,
  // Wire level of the data line
  input wire logic sda_i,
  // Clock line and data pull-down
  output logic scl_o,
  output logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic bit_io(input logic b, output logic r);
    @(posedge clock_i);
    scl_o <= 1'b0;
    tick(2);
    sda_low_o <= ~b;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    r = sda_i;
    tick(2);
  endtask

  task automatic cond(input logic stop);
    @(posedge clock_i);
    scl_o <= 1'b0;
    tick(2);
    sda_low_o <= stop;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= ~stop;
    tick(4);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Partial byte for aborts
  task automatic send_nibble(input logic [3:0] d);
    logic r;
    for (int i = 3; i >= 0; i--) begin
      bit_io(d[i], r);
    end
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

// ---- verification/nvsram_i2c_slave_port_test.sv ----
// Self-checking bench for the two-wire slave port
module nvsram_i2c_slave_port_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0] STRAPS = 3'h5;
  localparam logic [7:0] SEL_W = {nvsram_i2c_pkg::MEM_DEV_CODE, STRAPS, 1'b0};
  localparam logic [7:0] SEL_R = {nvsram_i2c_pkg::MEM_DEV_CODE, STRAPS, 1'b1};
  localparam logic [7:0] PAT [4] = '{8'h96, 8'h01, 8'hfe, 8'h6b};

  logic clock_i;
  logic rst_i;
  logic link_clk_i;
  logic scl;
  logic sda_wire;
  logic master_low;
  logic sda_o;
  logic sda_oe_o;
  logic [2:0] straps;
  logic wp;
  logic bus_busy_o;
  logic hs_mode_o;
  logic write_strobe_o;
  int error_cnt = 0;
  int checked = 0;
  int strobes = 0;
  int cycles = 0;

  // Open-drain data line with pull-up
  assign sda_wire = ~(sda_oe_o | master_low);

  nvsram_i2c_slave_port i_nvsram_i2c_slave_port (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .link_clk_i(link_clk_i),
    .scl_i(scl),
    .sda_i(sda_wire),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .slave_select_straps_i(straps),
    .write_protect_i(wp),
    .bus_busy_o(bus_busy_o),
    .hs_mode_o(hs_mode_o),
    .write_strobe_o(write_strobe_o)
  );

  i2c_master_model i_i2c_master_model (
    .clock_i(clock_i),
    .sda_i(sda_wire),
    .scl_o(scl),
    .sda_low_o(master_low)
  );

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  initial begin
    link_clk_i = 1'b0;
    #3;
    forever #6 link_clk_i = ~link_clk_i;
  end

  always @(negedge clock_i) begin
    if (write_strobe_o === 1'b1) begin
      strobes++;
    end
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      print_verdict();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic wait_core(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // Start, select for write, two address bytes
  task automatic point(input logic [12:0] a, input logic [2:0] junk, output logic ok);
    logic a1;
    logic a2;
    logic a3;
    i_i2c_master_model.cond(1'b0);
    i_i2c_master_model.send_byte(SEL_W, a1);
    i_i2c_master_model.send_byte({junk, a[12:8]}, a2);
    i_i2c_master_model.send_byte(a[7:0], a3);
    ok = a1 & a2 & a3;
  endtask

  task automatic read_one(output logic [7:0] d, output logic ack);
    i_i2c_master_model.cond(1'b0);
    i_i2c_master_model.send_byte(SEL_R, ack);
    i_i2c_master_model.recv_byte(1'b0, d);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_burst();
    logic ack;
    logic [7:0] d;
    strobes = 0;
    point(13'h1ffe, 3'h7, ack);
    check(ack === 1'b1, "select and address ack");
    wait_core(1);
    check(bus_busy_o === 1'b1, "busy in transfer");
    for (int i = 0; i < 4; i++) begin
      i_i2c_master_model.send_byte(PAT[i], ack);
      check(ack === 1'b1, "burst data ack");
    end
    i_i2c_master_model.cond(1'b1);
    wait_core(10);
    check(bus_busy_o === 1'b0, "busy after stop");
    check(strobes == 4, "strobe count");
    point(13'h1ffe, 3'h0, ack);
    i_i2c_master_model.cond(1'b0);
    i_i2c_master_model.send_byte(SEL_R, ack);
    check(ack === 1'b1, "read select ack");
    for (int i = 0; i < 3; i++) begin
      i_i2c_master_model.recv_byte(i < 2, d);
      check(d === PAT[i], "random read data");
    end
    wait_core(4);
    check(sda_oe_o === 1'b0, "line released after nack");
    check(sda_o === 1'b0, "open drain value");
    read_one(d, ack);
    check(d === PAT[3], "current address read");
    i_i2c_master_model.cond(1'b1);
  endtask

  task automatic t_foreign();
    logic ack;
    i_i2c_master_model.cond(1'b0);
    i_i2c_master_model.send_byte({nvsram_i2c_pkg::MEM_DEV_CODE, ~STRAPS, 1'b0}, ack);
    check(ack === 1'b0, "foreign select nack");
    i_i2c_master_model.send_byte(8'h00, ack);
    check(ack === 1'b0, "ignored after foreign select");
    i_i2c_master_model.cond(1'b0);
    i_i2c_master_model.send_byte(8'hf0, ack);
    check(ack === 1'b0, "extended address nack");
    i_i2c_master_model.cond(1'b0);
    i_i2c_master_model.send_byte(SEL_W, ack);
    check(ack === 1'b1, "fresh select after restart");
    i_i2c_master_model.cond(1'b1);
    @(posedge clock_i);
    straps <= 3'h2;
    wait_core(4);
    i_i2c_master_model.cond(1'b0);
    i_i2c_master_model.send_byte({nvsram_i2c_pkg::MEM_DEV_CODE, 3'h2, 1'b0}, ack);
    check(ack === 1'b1, "select on new straps");
    i_i2c_master_model.cond(1'b0);
    i_i2c_master_model.send_byte(SEL_W, ack);
    check(ack === 1'b0, "old straps refused");
    i_i2c_master_model.cond(1'b1);
    @(posedge clock_i);
    straps <= STRAPS;
    wait_core(4);
  endtask

  task automatic t_protect();
    logic ack;
    logic [7:0] d;
    point(13'h0010, 3'h0, ack);
    i_i2c_master_model.send_byte(8'h21, ack);
    i_i2c_master_model.cond(1'b1);
    @(posedge clock_i);
    wp <= 1'b1;
    strobes = 0;
    point(13'h0010, 3'h0, ack);
    i_i2c_master_model.send_byte(8'h77, ack);
    check(ack === 1'b0, "protected byte nack");
    i_i2c_master_model.cond(1'b1);
    @(posedge clock_i);
    wp <= 1'b0;
    wait_core(10);
    check(strobes == 0, "no write when protected");
    point(13'h0010, 3'h0, ack);
    read_one(d, ack);
    check(d === 8'h21, "protected content kept");
    i_i2c_master_model.cond(1'b1);
  endtask

  task automatic t_midbyte();
    logic ack;
    logic [7:0] d;
    strobes = 0;
    point(13'h0010, 3'h0, ack);
    i_i2c_master_model.send_nibble(4'ha);
    read_one(d, ack);
    check(ack === 1'b1, "select after mid-byte restart");
    check(d === 8'h21, "partial byte discarded");
    i_i2c_master_model.cond(1'b1);
    wait_core(10);
    check(strobes == 0, "no strobe for partial byte");
  endtask

  task automatic t_hs();
    logic ack;
    i_i2c_master_model.cond(1'b0);
    i_i2c_master_model.send_byte(8'h0d, ack);
    check(ack === 1'b0, "master code nack");
    wait_core(1);
    check(hs_mode_o === 1'b1, "high speed entered");
    i_i2c_master_model.cond(1'b0);
    i_i2c_master_model.send_byte(SEL_W, ack);
    check(ack === 1'b1, "select in high speed");
    check(hs_mode_o === 1'b1, "high speed kept over restart");
    i_i2c_master_model.cond(1'b1);
    wait_core(10);
    check(hs_mode_o === 1'b0, "high speed left at stop");
  endtask

  task automatic print_verdict();
    $display("Mismatches %0d, checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    wp = 1'b0;
    straps = STRAPS;
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    t_burst();
    t_foreign();
    t_protect();
    t_midbyte();
    t_hs();
    print_verdict();
  end
endmodule
